/* File: rtl/usb_dma_route_pkg.sv */
// constants shared by the usb read-endpoint dma request router
package usb_dma_route_pkg;

    // ------------------------------------------------------------------
    // register offsets (word index on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;  // usb_dma_transfer_control
    localparam logic [3:0] STATUS_OFFSET = 4'h1;  // routing status, read only

    // ------------------------------------------------------------------
    // usb_dma_transfer_control fields
    // ------------------------------------------------------------------
    localparam int READ_ENDPOINT_DMA_ENABLE_BIT = 15;
    localparam int READ_CHANNEL_SELECT_HI_BIT   = 14;
    localparam int READ_CHANNEL_SELECT_LO_BIT   = 13;
    localparam int RESERVED_BIT                 = 12;

    // ------------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------------
    localparam int STATUS_ACTIVE_LSB = 0;   // dma_active of the four channels
    localparam int STATUS_HOLD_BIT   = 4;   // a word waits for the channel
    localparam int STATUS_LEVEL_LSB  = 8;   // fifo fill level, 5 bits
    localparam int STATUS_LEVEL_W    = 5;

    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic       ENABLE_RESET   = 1'b0;
    localparam logic [1:0] SELECT_RESET   = 2'h0;
    localparam logic       RESERVED_RESET = 1'b0;
    localparam logic [15:0] RDATA_RESET   = 16'h0000;
    localparam int CHANNELS     = 4;
    localparam int DATA_W       = 16;
    localparam int FIFO_DEPTH   = 16;
    localparam int FIFO_MAX_DEPTH = 16;

endpackage : usb_dma_route_pkg

/* File: rtl/word_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // filling side
    input  wire logic [WIDTH-1:0]           in_data,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    // draining side
    output logic [WIDTH-1:0]                out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    // fill level
    output logic [$clog2(DEPTH):0]          level
);

    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("word_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        full;
    } fifo_state_t;

    fifo_state_t state;
    fifo_state_t next_state;
    logic        push;
    logic        pop;

    // full is kept as its own flop so that in_ready is a clean register
    assign push      = in_valid && !state.full;
    assign pop       = out_ready && (state.count != '0);
    assign in_ready  = !state.full;
    assign out_valid = state.count != '0;
    assign out_data  = state.mem[state.rd_ptr];
    assign level     = state.count;

    // pointer and count update
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wr_ptr] = in_data;
            next_state.wr_ptr = state.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_state.rd_ptr = state.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_state.count = state.count + 1'b1;
        end else if (pop && !push) begin
            next_state.count = state.count - 1'b1;
        end
        next_state.full = next_state.count == (AW + 1)'(DEPTH);
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule // word_fifo

`default_nettype wire

/* File: rtl/usb_read_dma_route.sv */
// routes usb read-endpoint transfer requests to one of four dma channels
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - enable set makes usb request activation source
// - data flows out of usb endpoint to dma
// - accepting channel ignores its external request pin
// - select 00..11 picks channel 0..3
// - selected channel answers usb request, not pin
module usb_read_dma_route #(
    parameter int DATA_W     = usb_dma_route_pkg::DATA_W,
    parameter int FIFO_DEPTH = usb_dma_route_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                 MCLK,
    input  wire logic                 RESET_N,
    // register port
    input  wire logic [3:0]           REG_ADDR,
    input  wire logic [15:0]          REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic [15:0]               REG_RDATA,
    // usb read endpoint fifo side
    input  wire logic [DATA_W-1:0]    USB_RD_DATA,
    input  wire logic                 USB_RD_VALID,
    output logic                      USB_RD_READY,
    // dma channel side
    input  wire logic [3:0]           EXT_EXTERNAL_DMA_REQUEST_PIN,
    input  wire logic [3:0]           DMA_ACTIVE,
    output logic [3:0]                CH_REQ,
    input  wire logic [3:0]           CH_ACK,
    output logic [DATA_W-1:0]         CH_DATA
);

    localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (FIFO_DEPTH > usb_dma_route_pkg::FIFO_MAX_DEPTH || FIFO_DEPTH < 2) begin : g_bad_depth
        $error("usb_read_dma_route: fifo depth must lie in 2..16");
    end
    if (DATA_W < 1) begin : g_bad_width
        $error("usb_read_dma_route: data width must be positive");
    end

    // ------------------------------------------------------------------
    // behaviour in brief
    // ------------------------------------------------------------------
    // control word, offset 0:
    //   bit 15  enable for the read-endpoint request path
    //   bit 14  routed channel, high bit
    //   bit 13  routed channel, low bit
    //   bit 12  plain storage bit, reads back what was written
    //   others  read as zero, writes to them are dropped
    // status word, offset 1, read only:
    //   bits 3:0   active flags of the four channels, passed through
    //   bit 4      output stage holds a word for the routed channel
    //   bits 12:8  number of words waiting in the fifo
    // data path: endpoint -> fifo -> one-word output stage -> channel.
    // the stage is what the routed channel sees; its request is high
    // exactly while the stage is full, and each ack on that channel
    // takes one word and lets the next one in on the same edge.
    // channels that are not routed copy their pin one cycle late, so
    // every request output is a flop and an unrouted pin sees one cycle of
    // latency; the pin of the routed channel is not seen at all.
    // limitation: nothing here stops software from moving the route
    // while a channel is mid-transfer; a word left in the stage then
    // simply waits for the new channel, so the old one may see a
    // short run. keeping the route still is the driver's job.
    // the fifo keeps filling while the path is disabled, which lets
    // software arm the channel after the first words have arrived.
    // reset puts the path back on the pins: enable and select clear,
    // and any word in the stage or fifo is lost.

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              enable;      // read_endpoint_dma_enable
        logic [1:0]        sel;         // read_channel_select_hi/lo
        logic              reserved;    // stored, no effect
        logic              hold_valid;  // output stage holds a word
        logic [DATA_W-1:0] hold_data;
        logic [3:0]        req;         // activation request per channel
        logic [15:0]       rdata;
    } route_state_t;

    route_state_t state;
    route_state_t next_state;

    logic [DATA_W-1:0]  fifo_out_data;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [LEVEL_W-1:0] fifo_level;
    logic               fifo_in_ready;
    logic               pop;

    // ------------------------------------------------------------------
    // endpoint data buffer
    // ------------------------------------------------------------------
    // words travel from the usb endpoint toward the dma channel only
    word_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .reset_n   (RESET_N),
        .in_data   (USB_RD_DATA),
        .in_valid  (USB_RD_VALID),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .level     (fifo_level)
    );

    // an ack from a channel that is not the routed one never pops the stage
    assign pop            = state.enable && state.hold_valid && CH_ACK[state.sel];
    // the stage refills from the fifo when empty or being emptied
    assign fifo_out_ready = !state.hold_valid || pop;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;

        // register writes; the router trusts software to leave the
        // enable and select alone while the routed channel is active
        if (REG_WR && REG_ADDR == usb_dma_route_pkg::CTRL_OFFSET) begin
            next_state.enable =
                REG_WDATA[usb_dma_route_pkg::READ_ENDPOINT_DMA_ENABLE_BIT];
            next_state.sel = {
                REG_WDATA[usb_dma_route_pkg::READ_CHANNEL_SELECT_HI_BIT],
                REG_WDATA[usb_dma_route_pkg::READ_CHANNEL_SELECT_LO_BIT]};
            next_state.reserved = REG_WDATA[usb_dma_route_pkg::RESERVED_BIT];
        end

        // output stage: hand the head word to the routed channel
        if (fifo_out_ready) begin
            next_state.hold_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_state.hold_data = fifo_out_data;
            end
        end

        // request routing, computed from the next stage so that the
        // request drops in the same cycle the last word is taken
        for (int c = 0; c < usb_dma_route_pkg::CHANNELS; c++) begin
            if (next_state.enable && next_state.sel == 2'(c)) begin
                // usb request replaces the external pin on this channel
                next_state.req[c] = next_state.hold_valid;
            end else begin
                next_state.req[c] = EXT_EXTERNAL_DMA_REQUEST_PIN[c];
            end
        end

        // register reads, answered in the following cycle only
        next_state.rdata = usb_dma_route_pkg::RDATA_RESET;
        if (REG_RD) begin
            case (REG_ADDR)
                usb_dma_route_pkg::CTRL_OFFSET: begin
                    next_state.rdata[usb_dma_route_pkg::READ_ENDPOINT_DMA_ENABLE_BIT] =
                        state.enable;
                    next_state.rdata[usb_dma_route_pkg::READ_CHANNEL_SELECT_HI_BIT] =
                        state.sel[1];
                    next_state.rdata[usb_dma_route_pkg::READ_CHANNEL_SELECT_LO_BIT] =
                        state.sel[0];
                    next_state.rdata[usb_dma_route_pkg::RESERVED_BIT] = state.reserved;
                end
                usb_dma_route_pkg::STATUS_OFFSET: begin
                    next_state.rdata[usb_dma_route_pkg::STATUS_ACTIVE_LSB +: 4] =
                        DMA_ACTIVE;
                    next_state.rdata[usb_dma_route_pkg::STATUS_HOLD_BIT] =
                        state.hold_valid;
                    next_state.rdata[usb_dma_route_pkg::STATUS_LEVEL_LSB +:
                                     usb_dma_route_pkg::STATUS_LEVEL_W] =
                        usb_dma_route_pkg::STATUS_LEVEL_W'(fifo_level);
                end
                default: begin
                    // unmapped offsets read as zero
                    next_state.rdata = usb_dma_route_pkg::RDATA_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // reset leaves every channel on its external pin
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state.enable     <= usb_dma_route_pkg::ENABLE_RESET;
            state.sel        <= usb_dma_route_pkg::SELECT_RESET;
            state.reserved   <= usb_dma_route_pkg::RESERVED_RESET;
            state.hold_valid <= 1'b0;
            state.hold_data  <= '0;
            state.req        <= '0;
            state.rdata      <= usb_dma_route_pkg::RDATA_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign REG_RDATA    = state.rdata;
    assign CH_REQ       = state.req;
    assign CH_DATA      = state.hold_data;
    assign USB_RD_READY = fifo_in_ready;  // registered full flag inside the fifo

endmodule // usb_read_dma_route

`default_nettype wire

/* File: testbench/usb_read_dma_route_assertions.sv */
// checker for the usb read-endpoint dma request router
`timescale 1ns/1ps
`default_nettype none

module usb_read_dma_route_assertions #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic              MCLK, RESET_N,
    // register port
    input wire logic [3:0]        REG_ADDR,
    input wire logic [15:0]       REG_WDATA, REG_RDATA,
    input wire logic              REG_WR, REG_RD,
    // usb side
    input wire logic [DATA_W-1:0] USB_RD_DATA,
    input wire logic              USB_RD_VALID, USB_RD_READY,
    // channel side
    input wire logic [3:0]        EXT_EXTERNAL_DMA_REQUEST_PIN, DMA_ACTIVE, CH_REQ, CH_ACK,
    input wire logic [DATA_W-1:0] CH_DATA
);
    // ------------------------------------------------------------
    // shadow of the control word, built from the writes seen
    // ------------------------------------------------------------
    logic       en;
    logic [1:0] sel;
    logic       res;
    logic [3:0] route;
    logic [3:0] prev;  // routing one edge back; route is what built CH_REQ now
    assign route = en ? (4'h1 << sel) : 4'h0;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {en, sel, res, prev} <= '0;
        end else begin
            prev <= route;
            if (REG_WR && REG_ADDR == usb_dma_route_pkg::CTRL_OFFSET) begin
                {en, sel, res} <= REG_WDATA[15:12];
            end
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    // routed stage holds a word, nothing takes it and routing stays put
    sequence s_hold;
        (CH_REQ & prev) != 4'h0 && (CH_ACK & prev) == 4'h0 && prev == route && !REG_WR;
    endsequence

    property p_rdata_idle; !$past(REG_RD) |-> REG_RDATA == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_rdata_ctrl;
        REG_RD && REG_ADDR == usb_dma_route_pkg::CTRL_OFFSET |=> REG_RDATA == {en, sel, res, 12'h000};
    endproperty
    a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control readback wrong");
    property p_rdata_unmapped; REG_RD && REG_ADDR > 4'h1 |=> REG_RDATA == 16'h0000; endproperty
    a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not 0");
    property p_status_active;
        REG_RD && REG_ADDR == usb_dma_route_pkg::STATUS_OFFSET |=> REG_RDATA[3:0] == $past(DMA_ACTIVE);
    endproperty
    a_status_active: assert property (p_status_active) else $error("status active wrong");
    property p_mirror; (CH_REQ & ~route) == ($past(EXT_EXTERNAL_DMA_REQUEST_PIN) & ~route); endproperty
    a_mirror: assert property (p_mirror) else $error("unrouted channel not pin");
    property p_req_holds; s_hold |=> (CH_REQ & prev) != 4'h0; endproperty
    a_req_holds: assert property (p_req_holds) else $error("request dropped without ack");
    property p_data_stable; s_hold |=> $stable(CH_DATA); endproperty
    a_data_stable: assert property (p_data_stable) else $error("word changed without ack");
    property p_ready_stall; !USB_RD_READY ##0 s_hold |=> !USB_RD_READY; endproperty
    a_ready_stall: assert property (p_ready_stall) else $error("ready rose without pop");
endmodule // usb_read_dma_route_assertions
`default_nettype wire

/* File: testbench/usb_ep_model.sv */
// behavioural usb read endpoint that offers a run of words
`timescale 1ns/1ps
`default_nettype none

module usb_ep_model (
    input  wire logic        clk, reset_n, go, ready,
    input  wire logic [15:0] base,
    input  wire logic [7:0]  count,
    output logic [15:0]      data,
    output logic             valid
);
    logic [7:0] left;
    // offer is held until ready is seen at an edge; idle lines show the inverse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {valid, data, left} <= '0;
        end else if (valid && ready) begin
            left  <= left - 8'h01;
            valid <= (left != 8'h01);
            data  <= (left != 8'h01) ? data + 16'h0001 : ~data;
        end else if (go && !valid) begin
            {valid, data, left} <= {1'b1, base, count};
        end
    end
endmodule // usb_ep_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the usb read-endpoint dma request router
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module testbench;
    logic        MCLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, go = 0;
    logic [3:0]  REG_ADDR = 0, EXT_EXTERNAL_DMA_REQUEST_PIN = 0, DMA_ACTIVE = 0, CH_ACK = 0, CH_REQ;
    logic [15:0] REG_WDATA = 0, base = 0, d, REG_RDATA, USB_RD_DATA, CH_DATA;
    logic        USB_RD_VALID, USB_RD_READY;
    logic [7:0]  count = 0;
    int          bad_count = 0, tests_run = 0;

    usb_read_dma_route uut (.MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .USB_RD_DATA(USB_RD_DATA), .USB_RD_VALID(USB_RD_VALID), .USB_RD_READY(USB_RD_READY),
        .EXT_EXTERNAL_DMA_REQUEST_PIN(EXT_EXTERNAL_DMA_REQUEST_PIN), .DMA_ACTIVE(DMA_ACTIVE), .CH_REQ(CH_REQ), .CH_ACK(CH_ACK),
        .CH_DATA(CH_DATA));
    usb_ep_model ep (.clk(MCLK), .reset_n(RESET_N), .go(go), .ready(USB_RD_READY),
        .base(base), .count(count), .data(USB_RD_DATA), .valid(USB_RD_VALID));

    initial forever #5 MCLK = ~MCLK;

    // ------------------------------------------------------------
    // register port and stream tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge MCLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, v};
        @(posedge MCLK) REG_WR <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge MCLK) {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge MCLK) REG_RD <= 1'b0;
        @(negedge MCLK) v = REG_RDATA;
    endtask
    task automatic send(input logic [15:0] b, input logic [7:0] n);
        @(posedge MCLK) {go, base, count} <= {1'b1, b, n};
        @(posedge MCLK) go <= 1'b0;
    endtask
    // take n words from channel c, one ack per word, checking the order
    task automatic drain(input int c, input int n, input logic [15:0] b);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin @(negedge MCLK); k++; end while (CH_REQ[c] !== 1'b1 && k < 50);
            `CHECK("ch_req", 1'b1, CH_REQ[c])
            `CHECK("ch_data", b + 16'(i), CH_DATA)
            @(posedge MCLK) CH_ACK[c] <= 1'b1;
            @(posedge MCLK) CH_ACK[c] <= 1'b0;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        results;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge MCLK);
        RESET_N <= 1'b1;
        rd(usb_dma_route_pkg::CTRL_OFFSET, d);
        `CHECK("ctrl_reset", 16'h0000, d)
        rd(4'h7, d);
        `CHECK("unmapped", 16'h0000, d)
        wr(usb_dma_route_pkg::CTRL_OFFSET, 16'hffff);
        rd(usb_dma_route_pkg::CTRL_OFFSET, d);
        `CHECK("ctrl_rw", 16'hf000, d)
        wr(usb_dma_route_pkg::CTRL_OFFSET, 16'h0000);
        @(posedge MCLK) {EXT_EXTERNAL_DMA_REQUEST_PIN, DMA_ACTIVE} <= 8'h5a;
        rd(usb_dma_route_pkg::STATUS_OFFSET, d);
        `CHECK("status_active", 4'ha, d[3:0])
        `CHECK("pins_disabled", 4'h5, CH_REQ)
        @(posedge MCLK) {EXT_EXTERNAL_DMA_REQUEST_PIN, DMA_ACTIVE} <= 8'hf0;
        // channels idle, all four pins high while each channel in turn is routed
        for (int c = 0; c < 4; c++) begin
            wr(usb_dma_route_pkg::CTRL_OFFSET, {1'b1, 2'(c), 13'h0000});
            send(16'h1000 << c, 8'h03);
            drain(c, 3, 16'h1000 << c);
            repeat (3) @(negedge MCLK);
            `CHECK("pin_ignored", 4'hf & ~(4'h1 << c), CH_REQ)
        end
        // stall the channel until the fifo refuses, then drain it all
        wr(usb_dma_route_pkg::CTRL_OFFSET, 16'ha000);
        @(posedge MCLK) EXT_EXTERNAL_DMA_REQUEST_PIN <= 4'h0;
        send(16'h2000, 8'h14);
        repeat (60) @(negedge MCLK);
        `CHECK("ready_full", 1'b0, USB_RD_READY)
        // acks on channels that are not routed must take nothing
        @(posedge MCLK) CH_ACK <= 4'hd;
        @(posedge MCLK) CH_ACK <= 4'h0;
        rd(usb_dma_route_pkg::STATUS_OFFSET, d);
        `CHECK("fifo_level", 5'h10, d[12:8])
        `CHECK("stage_hold", 1'b1, d[4])
        drain(1, 20, 16'h2000);
        `CHECK("ready_empty", 1'b1, USB_RD_READY)
        results;
    end
endmodule // testbench

bind usb_read_dma_route usb_read_dma_route_assertions #(.DATA_W(DATA_W)) chk (
    .MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .USB_RD_DATA(USB_RD_DATA),
    .USB_RD_VALID(USB_RD_VALID), .USB_RD_READY(USB_RD_READY), .EXT_EXTERNAL_DMA_REQUEST_PIN(EXT_EXTERNAL_DMA_REQUEST_PIN),
    .DMA_ACTIVE(DMA_ACTIVE), .CH_REQ(CH_REQ), .CH_ACK(CH_ACK), .CH_DATA(CH_DATA));
`default_nettype wire
